// ---- pkg/idp_map.vh ----
// What this block does
// - Word 0: ATA, fixed media, bit6 set
// - Words 10-19: serial, twenty chars, right-justified
// - Words 27-46: model, forty chars, space padded
// - Words 23-26: firmware revision, eight chars, left-justified
// - Word 49: flow-control ready, LBA, DMA bits set
// - Word 51 PIO mode 2; word 64 modes 3,4
// - Word 53 flags words 88, 64-70, 54-58 valid
// - Word 59: multiple count, only 2/4/8/16
// - Word 63: selected and supported multiword DMA modes
// - Word 80: interface revisions one through five supported
// - Word 82: listed command set support bits set
// - Word 83: bits 14, 9, 8, 3 set
// - Word 85: current enables of supported features
// - Word 86: acoustic and power management enables
// - Word 88: selected and supported Ultra DMA modes
// - Word 89: security erase time, 0004H = 8 minutes
// - Word 93: 15 clear, 14 set, updates only in reset
// - Word 93 bit 13: cable detect level sampled
// - Device 1 fills bits 12-8; device 0 clears
// - Device 0 fills bits 7-4; device 1 clears
// - Device 0: diagnostics, numbering method, bit 0 set
// - Numbering method codes 01, 10, 11; never 00
// - Word 94: acoustic management level in effect
`ifndef IDP_MAP_VH
`define IDP_MAP_VH

`define IDP_REG_CTRL 10'h000
`define IDP_REG_FEAT 10'h001
`define IDP_REG_XFER 10'h002
`define IDP_REG_AAM 10'h003
`define IDP_REG_ERASE 10'h004
`define IDP_REG_STAT 10'h005
`define IDP_STR_SEL 4'h1

`define IDP_CTRL_RST 8'h00
`define IDP_FEAT_RST 16'h346B
`define IDP_XFER_RST 16'h0000
`define IDP_AAM_RST 10'h080
`define IDP_ERASE_RST 16'h0004

`define IDP_W0 16'h0040
`define IDP_W49 16'h0B00
`define IDP_W51 16'h0200
`define IDP_W53 16'h0007
`define IDP_W63_SUP 3'h7
`define IDP_W64 16'h0003
`define IDP_W80 16'h003E
`define IDP_W82 16'h346B
`define IDP_W83 16'h4308
`define IDP_W88_SUP 6'h3F
`define IDP_W93_RST 16'h4001
`define IDP_SPACE_PAIR 16'h2020
`define IDP_METH_UNKNOWN 2'h3

`define IDP_STR_FIRST 8'h0A
`define IDP_STR_LAST 8'h2E
`define IDP_PAGE_LAST 8'hFF
`define IDP_CMD_IDENTIFY 8'hEC

`endif

// ---- hdl/idp_str_mem.v ----
`timescale 1ns/100ps
`default_nettype none
`include "idp_map.vh"
module idp_str_mem
(
	input wire hclk,
	input wire hresetn,
	input wire wr_en,
	input wire [5:0] wr_addr,
	input wire [15:0] wr_data,
	input wire [5:0] rd_addr,
	output reg [15:0] rd_data_ff
);
	reg [15:0] mem_ff [0:63];
	integer i;

	// Every cell starts as two spaces so unused model positions read as padding.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (i = 0; i < 64; i = i + 1)
				mem_ff[i] <= `IDP_SPACE_PAIR;
			rd_data_ff <= 16'h0000;
		end
		else
		begin
			if (wr_en)
				mem_ff[wr_addr] <= wr_data;
			rd_data_ff <= mem_ff[rd_addr];
		end
	end
endmodule
`default_nettype wire

// ---- hdl/idp_rst_result.v ----
`timescale 1ns/100ps
`default_nettype none
`include "idp_map.vh"
module idp_rst_result
(
	input wire hclk,
	input wire hresetn,
	input wire hw_reset_act,
	input wire cable_det,
	input wire dev1_sel,
	input wire [1:0] num_method,
	input wire diag_passed,
	input wire dev0_resp_dev1,
	input wire pdiag_out,
	input wire pdiag_seen,
	input wire dasp_seen,
	output reg [15:0] word93_ff
);
	reg [1:0] meth;
	reg [15:0] nxt_word93;

	always @*
	begin
		meth = (num_method == 2'h0) ? `IDP_METH_UNKNOWN : num_method;
		if (dev1_sel)
			nxt_word93 = {2'b01, cable_det, 1'b0, pdiag_out, meth, 1'b1, 8'h00};
		else
			nxt_word93 = {2'b01, cable_det, 5'h00, 1'b0, dev0_resp_dev1, dasp_seen, pdiag_seen,
				diag_passed, meth, 1'b1};
	end

	// The word is frozen outside reset so the host never sees it drift.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			word93_ff <= `IDP_W93_RST;
		else if (hw_reset_act)
			word93_ff <= nxt_word93;
	end
endmodule
`default_nettype wire

// ---- hdl/idp_top.v ----
`timescale 1ns/100ps
`default_nettype none
`include "idp_map.vh"
module idp_top
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata_ff,
	output reg hreadyout_ff,
	output reg hresp_ff,
	input wire [7:0] cmd_code,
	input wire cmd_strobe,
	input wire id_ack,
	output reg id_valid_ff,
	output reg [15:0] id_data_ff,
	output reg [7:0] id_index_ff,
	output reg id_last_ff,
	output reg id_busy_ff,
	input wire hw_reset_act,
	input wire cable_det,
	input wire pdiag_out,
	input wire pdiag_seen,
	input wire dasp_seen
);
	localparam ST_IDLE = 2'd0;
	localparam ST_FETCH = 2'd1;
	localparam ST_LOAD = 2'd2;
	localparam ST_SHOW = 2'd3;

	reg [7:0] ctrl_ff;
	reg [15:0] feat_ff;
	reg [15:0] xfer_ff;
	reg [9:0] aam_ff;
	reg [15:0] erase_ff;

	reg wr_pend_ff;
	reg [9:0] wr_idx_ff;
	reg [3:0] wr_sel_ff;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [7:0] idx_ff;
	reg [7:0] nxt_idx;
	reg nxt_valid;
	reg nxt_last;
	reg nxt_busy;
	reg [15:0] nxt_data;

	wire addr_take;
	wire [9:0] a_idx;
	wire [5:0] str_rd_addr;
	wire [15:0] str_rd_data;
	wire [15:0] word93;
	wire str_wr;

	wire dev1_sel;
	wire [1:0] num_method;
	wire diag_passed;
	wire dev0_resp;
	wire [7:0] multi_cnt;
	wire multi_ok;
	wire mw_en;
	wire [1:0] mw_mode;
	wire ud_en;
	wire [2:0] ud_mode;
	wire aam_en;
	wire apm_en;
	wire [7:0] aam_level;

	reg [31:0] rd_mux;
	reg [15:0] page_word;
	wire [2:0] mw_sel;
	wire [5:0] ud_sel;
	wire str_word;
	genvar mw_g;
	genvar ud_g;

	assign addr_take = hsel & htrans[1] & hready;
	assign a_idx = haddr[11:2];
	assign str_wr = wr_pend_ff & (wr_sel_ff == `IDP_STR_SEL);

	assign dev1_sel = ctrl_ff[0];
	assign num_method = ctrl_ff[2:1];
	assign diag_passed = ctrl_ff[3];
	assign dev0_resp = ctrl_ff[4];
	assign multi_cnt = xfer_ff[7:0];
	assign mw_en = xfer_ff[8];
	assign mw_mode = xfer_ff[10:9];
	assign ud_en = xfer_ff[11];
	assign ud_mode = xfer_ff[14:12];
	assign aam_level = aam_ff[7:0];
	assign aam_en = aam_ff[8];
	assign apm_en = aam_ff[9];

	// Only the four legal block sizes count as a multiple transfer in force.
	assign multi_ok = (multi_cnt == 8'h02) | (multi_cnt == 8'h04) |
		(multi_cnt == 8'h08) | (multi_cnt == 8'h10);

	assign str_rd_addr = idx_ff[5:0] - 6'h0A;

	// Words 20 to 22 sit inside the string span but carry no text, so they read as zero.
	assign str_word = (idx_ff >= `IDP_STR_FIRST) && (idx_ff <= `IDP_STR_LAST) && (idx_ff != 8'd20) &&
		(idx_ff != 8'd21) && (idx_ff != 8'd22);

	idp_str_mem u_str
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(str_wr),
		.wr_addr(wr_idx_ff[5:0]),
		.wr_data(hwdata[15:0]),
		.rd_addr(str_rd_addr),
		.rd_data_ff(str_rd_data)
	);

	idp_rst_result u_rst
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.hw_reset_act(hw_reset_act),
		.cable_det(cable_det),
		.dev1_sel(dev1_sel),
		.num_method(num_method),
		.diag_passed(diag_passed),
		.dev0_resp_dev1(dev0_resp),
		.pdiag_out(pdiag_out),
		.pdiag_seen(pdiag_seen),
		.dasp_seen(dasp_seen),
		.word93_ff(word93)
	);

	// Selected-mode flags are one-hot. A mode code beyond the supported range
	// matches no bit, so the host sees nothing selected rather than a wrong mode.
	generate
		for (mw_g = 0; mw_g < 3; mw_g = mw_g + 1)
		begin : g_mw_sel
			assign mw_sel[mw_g] = mw_en & ({30'h0, mw_mode} == mw_g);
		end
	endgenerate

	generate
		for (ud_g = 0; ud_g < 6; ud_g = ud_g + 1)
		begin : g_ud_sel
			assign ud_sel[ud_g] = ud_en & ({29'h0, ud_mode} == ud_g);
		end
	endgenerate

	// Live words follow the control registers directly, so a change made while
	// a page is going out shows from the next word on.
	always @*
	begin
		case (idx_ff)
			8'd0: page_word = `IDP_W0;
			8'd49: page_word = `IDP_W49;
			8'd51: page_word = `IDP_W51;
			8'd53: page_word = `IDP_W53;
			8'd59: page_word = {7'h00, multi_ok, multi_ok ? multi_cnt : 8'h00};
			8'd63: page_word = {5'h00, mw_sel, 5'h00, `IDP_W63_SUP};
			8'd64: page_word = `IDP_W64;
			8'd80: page_word = `IDP_W80;
			8'd82: page_word = `IDP_W82;
			8'd83: page_word = `IDP_W83;
			8'd85: page_word = feat_ff & `IDP_W82;
			8'd86: page_word = {6'h00, aam_en, 5'h00, apm_en, 3'h0};
			8'd88: page_word = {2'h0, ud_sel, 2'h0, `IDP_W88_SUP};
			8'd89: page_word = erase_ff;
			8'd93: page_word = word93;
			8'd94: page_word = {8'h00, aam_level};
			default:
			begin
				if (str_word)
					page_word = str_rd_data;
				else
					page_word = 16'h0000;
			end
		endcase
	end

	// The host side walks the page word by word; the string memory needs one
	// cycle to answer, so each word passes FETCH then LOAD before it is shown.
	always @*
	begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_valid = id_valid_ff;
		nxt_last = id_last_ff;
		nxt_busy = id_busy_ff;
		nxt_data = id_data_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (cmd_strobe && cmd_code == `IDP_CMD_IDENTIFY)
				begin
					nxt_idx = 8'h00;
					nxt_busy = 1'b1;
					nxt_state = ST_FETCH;
				end
			end
			ST_FETCH:
				nxt_state = ST_LOAD;
			ST_LOAD:
			begin
				nxt_data = page_word;
				nxt_valid = 1'b1;
				nxt_last = (idx_ff == `IDP_PAGE_LAST);
				nxt_state = ST_SHOW;
			end
			ST_SHOW:
			begin
				if (id_ack)
				begin
					nxt_valid = 1'b0;
					nxt_last = 1'b0;
					if (idx_ff == `IDP_PAGE_LAST)
					begin
						nxt_busy = 1'b0;
						nxt_state = ST_IDLE;
					end
					else
					begin
						nxt_idx = idx_ff + 8'h01;
						nxt_state = ST_FETCH;
					end
				end
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// The index output follows the next index, so it already names the coming word while valid is low.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= ST_IDLE;
			idx_ff <= 8'h00;
			id_valid_ff <= 1'b0;
			id_last_ff <= 1'b0;
			id_busy_ff <= 1'b0;
			id_data_ff <= 16'h0000;
			id_index_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			id_valid_ff <= nxt_valid;
			id_last_ff <= nxt_last;
			id_busy_ff <= nxt_busy;
			id_data_ff <= nxt_data;
			id_index_ff <= nxt_idx;
		end
	end

	// Word 93 is readable here too, so software can confirm the reset result
	// without fetching the whole page.
	always @*
	begin
		rd_mux = 32'h00000000;
		if (haddr[11:8] == 4'h0)
		begin
			case (a_idx)
				`IDP_REG_CTRL: rd_mux = {24'h000000, ctrl_ff};
				`IDP_REG_FEAT: rd_mux = {16'h0000, feat_ff};
				`IDP_REG_XFER: rd_mux = {16'h0000, xfer_ff};
				`IDP_REG_AAM: rd_mux = {22'h000000, aam_ff};
				`IDP_REG_ERASE: rd_mux = {16'h0000, erase_ff};
				`IDP_REG_STAT: rd_mux = {15'h0000, id_busy_ff, word93};
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// Read data are latched in the address phase, so the slave never waits;
	// the price is that a read right behind a write to the same word sees the old value.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata_ff <= 32'h00000000;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 10'h000;
			wr_sel_ff <= 4'h0;
		end
		else
		begin
			wr_pend_ff <= addr_take & hwrite;
			if (addr_take)
			begin
				wr_idx_ff <= a_idx;
				wr_sel_ff <= haddr[11:8];
				if (!hwrite)
					hrdata_ff <= rd_mux;
			end
		end
	end

	// Writes land at the end of the data phase, once hwdata is valid. Offsets with
	// no register behind them are dropped, since the bus always answers OKAY.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_ff <= `IDP_CTRL_RST;
			feat_ff <= `IDP_FEAT_RST;
			xfer_ff <= `IDP_XFER_RST;
			aam_ff <= `IDP_AAM_RST;
			erase_ff <= `IDP_ERASE_RST;
		end
		else if (wr_pend_ff && wr_sel_ff == 4'h0)
		begin
			case (wr_idx_ff)
				`IDP_REG_CTRL: ctrl_ff <= {3'h0, hwdata[4:0]};
				`IDP_REG_FEAT: feat_ff <= hwdata[15:0];
				`IDP_REG_XFER: xfer_ff <= {1'b0, hwdata[14:0]};
				`IDP_REG_AAM: aam_ff <= hwdata[9:0];
				`IDP_REG_ERASE: erase_ff <= hwdata[15:0];
				default: ctrl_ff <= ctrl_ff;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- testbench/idp_top_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module idp_top_checker
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_strobe,
	input wire logic id_ack,
	input wire logic id_valid_ff,
	input wire logic [15:0] id_data_ff,
	input wire logic [7:0] id_index_ff,
	input wire logic id_last_ff,
	input wire logic id_busy_ff
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Starts at 8'hFF so that the first word of a page must carry index 0.
	logic [7:0] acked_ff;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			acked_ff <= 8'hFF;
		else if (id_valid_ff && id_ack)
			acked_ff <= id_index_ff;
	word_zero_a: assert property (id_valid_ff && id_index_ff == 8'h00 |-> id_data_ff == 16'h0040)
		else $error("word 0 wrong");
	cap_word_a: assert property (id_valid_ff && id_index_ff == 8'h31 |-> id_data_ff == 16'h0B00)
		else $error("word 49 wrong");
	valid_word_a: assert property (id_valid_ff && id_index_ff == 8'h35 |-> id_data_ff == 16'h0007)
		else $error("word 53 wrong");
	cmd_sup_a: assert property (id_valid_ff && id_index_ff == 8'h53 |-> id_data_ff == 16'h4308)
		else $error("word 83 wrong");
	reset_fixed_a: assert property (id_valid_ff && id_index_ff == 8'h5D |-> id_data_ff[15:14] == 2'b01)
		else $error("word 93 fixed bits wrong");
	last_flag_a: assert property (id_valid_ff |-> id_last_ff == (id_index_ff == 8'hFF))
		else $error("last flag wrong");
	word_hold_a: assert property (id_valid_ff && !id_ack |=> id_valid_ff && $stable(id_data_ff))
		else $error("word not held");
	index_step_a: assert property ($rose(id_valid_ff) |-> id_index_ff == 8'(acked_ff + 8'h01))
		else $error("index out of order");
	next_word_a: assert property (id_valid_ff && id_ack && !id_last_ff |=> !id_valid_ff ##[1:3] id_valid_ff)
		else $error("next word late");
	page_end_a: assert property (id_valid_ff && id_ack && id_last_ff |=> !id_busy_ff && !id_valid_ff)
		else $error("page end wrong");
	page_start_a: assert property (cmd_strobe && cmd_code == 8'hEC && !id_busy_ff |-> ##[1:2] id_busy_ff)
		else $error("page not started");
endmodule
bind idp_top idp_top_checker chk (.hclk, .hresetn, .cmd_code, .cmd_strobe, .id_ack, .id_valid_ff, .id_data_ff,
	.id_index_ff, .id_last_ff, .id_busy_ff);
`default_nettype wire

// ---- testbench/idp_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module idp_host
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] host_wait,
	input wire logic id_valid_ff,
	input wire logic [15:0] id_data_ff,
	input wire logic [7:0] id_index_ff,
	output logic id_ack
);
	logic [15:0] page [256];
	logic [3:0] wait_ff;
	int count;
	// A slow host lets each word stand host_wait+2 cycles before it is taken, so the hold logic is exercised.
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			id_ack <= 1'b0;
			wait_ff <= 4'h0;
			count <= 0;
		end
		else if (id_ack)
		begin
			page[id_index_ff] <= id_data_ff;
			count <= count + 1;
			id_ack <= 1'b0;
			wait_ff <= 4'h0;
		end
		else if (id_valid_ff && wait_ff == host_wait)
			id_ack <= 1'b1;
		else if (id_valid_ff)
			wait_ff <= wait_ff + 4'h1;
endmodule
`default_nettype wire

// ---- testbench/idp_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module idp_top_bench;
	logic hclk, hresetn, hwrite, cmd_strobe, hw_reset_act, cable_det, pdiag_out, pdiag_seen, dasp_seen;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans;
	logic [7:0] cmd_code;
	wire logic [31:0] hrdata_ff;
	wire logic hreadyout_ff, hresp_ff, id_ack, id_valid_ff, id_last_ff, id_busy_ff;
	wire logic [15:0] id_data_ff;
	wire logic [7:0] id_index_ff;
	int bad_count, check_count;
	logic [23:0] rows [21];
	idp_top dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout_ff),
		.hwdata, .hrdata_ff, .hreadyout_ff, .hresp_ff, .cmd_code, .cmd_strobe, .id_ack, .id_valid_ff,
		.id_data_ff, .id_index_ff, .id_last_ff, .id_busy_ff, .hw_reset_act, .cable_det, .pdiag_out,
		.pdiag_seen, .dasp_seen);
	idp_host host (.hclk, .hresetn, .host_wait(4'h2), .id_valid_ff, .id_data_ff, .id_index_ff, .id_ack);
	task check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout_ff !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout_ff !== 1'b1);
		rd = hrdata_ff;
	endtask
	task pulse_cmd(input logic [7:0] c);
		@(posedge hclk);
		cmd_code <= c;
		cmd_strobe <= 1'b1;
		@(posedge hclk);
		cmd_strobe <= 1'b0;
	endtask
	task hw_rst;
		@(posedge hclk);
		hw_reset_act <= 1'b1;
		@(posedge hclk);
		hw_reset_act <= 1'b0;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial
	begin
		#2000000;
		bad_count++;
		give_verdict;
	end
	initial
	begin
		rows = '{24'h000040, 24'h0A4142, 24'h173130, 24'h1B4D44, 24'h2E2020,
			24'h310B00, 24'h330200, 24'h400003, 24'h350007, 24'h3B0110,
			24'h3F0407, 24'h50003E, 24'h52346B, 24'h534308, 24'h55346B,
			24'h560208, 24'h58203F, 24'h590006, 24'h5D605F, 24'h5E0055, 24'hFF0000};
		hresetn = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		cmd_code = 8'h00;
		cmd_strobe = 1'b0;
		hw_reset_act = 1'b0;
		cable_det = 1'b1;
		pdiag_out = 1'b0;
		pdiag_seen = 1'b1;
		dasp_seen = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b1, 32'h0, 32'h18);
		ahb(1'b1, 32'h4, 32'hFFFF);
		ahb(1'b1, 32'h8, 32'h5D10);
		ahb(1'b1, 32'hC, 32'h355);
		ahb(1'b1, 32'h10, 32'h6);
		ahb(1'b1, 32'h100, 32'h4142);
		ahb(1'b1, 32'h134, 32'h3130);
		ahb(1'b1, 32'h144, 32'h4D44);
		hw_rst;
		pulse_cmd(8'hEC);
		repeat (20) @(posedge hclk);
		pulse_cmd(8'hEC);
		@(negedge id_busy_ff);
		repeat (10) @(posedge hclk);
		check({31'h0, id_busy_ff}, 32'h0);
		check(host.count, 256);
		foreach (rows[i])
			check({16'h0, host.page[rows[i][23:16]]}, {16'h0, rows[i][15:0]});
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h4, 32'h0);
		check(rd, 32'h346B);
		ahb(1'b0, 32'hC, 32'h0);
		check(rd, 32'h80);
		ahb(1'b0, 32'h10, 32'h0);
		check(rd, 32'h4);
		ahb(1'b0, 32'h14, 32'h0);
		check(rd, 32'h4001);
		ahb(1'b1, 32'h0, 32'h3);
		pdiag_out <= 1'b1;
		cable_det <= 1'b0;
		hw_rst;
		ahb(1'b0, 32'h14, 32'h0);
		check(rd, 32'h4B00);
		cable_det <= 1'b1;
		ahb(1'b0, 32'h14, 32'h0);
		check(rd, 32'h4B00);
		check({31'h0, hresp_ff}, 32'h0);
		ahb(1'b0, 32'h40, 32'h0);
		check(rd, 32'h0);
		dasp_seen <= 1'b1;
		pdiag_seen <= 1'b0;
		ahb(1'b1, 32'h0, 32'h4);
		hw_rst;
		ahb(1'b0, 32'h14, 32'h0);
		check(rd, 32'h6025);
		pulse_cmd(8'hEE);
		repeat (4) @(posedge hclk);
		check({31'h0, id_busy_ff}, 32'h0);
		ahb(1'b1, 32'h8, 32'h6F03);
		pulse_cmd(8'hEC);
		@(negedge id_busy_ff);
		repeat (2) @(posedge hclk);
		check(host.count, 256);
		check({16'h0, host.page[59]}, 32'h0);
		check({16'h0, host.page[63]}, 32'h7);
		check({16'h0, host.page[88]}, 32'h3F);
		check({16'h0, host.page[10]}, 32'h2020);
		check({16'h0, host.page[93]}, 32'h6025);
		give_verdict;
	end
endmodule
`default_nettype wire
